// ### logic/dps_sequencer.sv
// diagnostic panel sequencer: launches panel-selected tests, shows codes.
// assumes debounced synchronous panel inputs and a test library that
// reports errors and pass ends as one-cycle pulses.
//
// The plain strobed port and the register addresses were decided locally.

module dps_sequencer #(
  parameter int unsigned GAP_CYCLES   = dps_pkg::GAP_CYCLES,
  parameter int unsigned FLASH_CYCLES = dps_pkg::FLASH_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // front panel
  input  wire dps_pkg::dps_panel_t pnl,
  output dps_pkg::dps_disp_t     disp,
  // host bus initialize; the register port is the other host-side input
  input  wire logic              bus_init,
  // test library
  input  wire dps_pkg::dps_eng_t eng,
  output dps_pkg::dps_cmd_t      cmd,
  // register port
  input  wire dps_pkg::dps_bus_t bus,
  output logic [15:0]            rdata
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (GAP_CYCLES < 2 || GAP_CYCLES >= (1 << dps_pkg::TMR_W)) begin : g_gap_chk
    $error("GAP_CYCLES out of range");
  end
  if (FLASH_CYCLES < 2 || FLASH_CYCLES >= (1 << dps_pkg::TMR_W)) begin : g_fl_chk
    $error("FLASH_CYCLES out of range");
  end

  localparam logic [dps_pkg::TMR_W-1:0] GAP_LAST =
    dps_pkg::TMR_W'(GAP_CYCLES - 1);
  localparam logic [dps_pkg::TMR_W-1:0] FLASH_LAST =
    dps_pkg::TMR_W'(FLASH_CYCLES - 1);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    dps_pkg::dps_state_t      st;
    logic                     btn_q;
    logic [2:0]               mode_q;
    logic [2:0]               class_q;
    logic                     repeat_q;
    logic                     wen;
    logic [2:0]               wen_mode;
    logic [4:0]               crc_cnt;
    logic [5:0]               err_code;
    logic                     err_flp;
    logic                     err_win;
    logic [dps_pkg::TMR_W-1:0] tmr;
    logic [dps_pkg::TMR_W-1:0] blink_tmr;
    logic                     blink;
    logic                     go;
    logic                     abort;
    logic                     drv_en;
    logic [6:0]               seg_hi;
    logic [6:0]               seg_lo;
    logic                     comp_lamp;
    logic                     flp_lamp;
    logic                     win_lamp;
    logic                     ctrl_inh;
    logic [15:0]              rdata;
  } dps_seq_t;

  dps_seq_t   s_r;
  dps_seq_t   s_nxt;
  logic [2:0] dig_hi;
  logic [2:0] dig_lo;
  logic       dig_blank;
  logic [6:0] seg_hi_w;
  logic [6:0] seg_lo_w;

  // ****************************************************************
  // functions
  // ****************************************************************
  // code marks a header or data CRC error, which only counts
  function automatic logic is_crc(input logic [5:0] code);
    is_crc = (code == dps_pkg::CODE_HCRC) || (code == dps_pkg::CODE_DCRC);
  endfunction

  // enter failure with a code and the drive it belongs to
  function automatic dps_seq_t fail(input dps_seq_t c, input logic [5:0] code,
                                    input logic flp, input logic win);
    dps_seq_t r;
    r          = c;
    r.st       = dps_pkg::ST_FAIL;
    r.err_code = code;
    r.err_flp  = flp;
    r.err_win  = win;
    r.tmr      = '0;
    fail       = r;
  endfunction

  // launch the selection on the switches, checking its needs first
  function automatic dps_seq_t launch(input dps_seq_t c, input dps_pkg::dps_panel_t p,
                                      input dps_pkg::dps_eng_t e);
    dps_seq_t r;
    logic     wen_ok;
    r          = c;
    r.mode_q   = p.mode_sw;
    r.class_q  = p.class_sw;
    r.crc_cnt  = '0;
    r.err_code = dps_pkg::CODE_OK;
    r.err_flp  = 1'b0;
    r.err_win  = 1'b0;
    r.tmr      = '0;
    wen_ok     = c.wen && (c.wen_mode == p.mode_sw);
    if (p.mode_sw == dps_pkg::MODE_BAD) begin
      // only modes zero to six exist
      r = fail(r, dps_pkg::CODE_BADCLS, 1'b0, 1'b0);
    end else if (p.class_sw == dps_pkg::CLASS_WEN &&
                 (p.mode_sw == dps_pkg::MODE_SYSTEM || p.mode_sw == dps_pkg::MODE_RW)) begin
      r.wen      = 1'b1;
      r.wen_mode = p.mode_sw;
      r.st       = dps_pkg::ST_DONE;
    end else if (e.req_floppy && !p.floppy_in) begin
      r = fail(r, dps_pkg::CODE_NRDY, 1'b1, 1'b0);
    end else if (e.req_fwrite && p.flp_wp) begin
      r = fail(r, dps_pkg::CODE_WPROT, 1'b1, 1'b0);
    end else if (e.req_wwrite && (p.win_wp || !wen_ok)) begin
      r = fail(r, dps_pkg::CODE_WPROT, 1'b0, 1'b1);
    end else begin
      r.st       = dps_pkg::ST_RUN;
      r.go       = 1'b1;
      r.repeat_q = 1'b0;
    end
    launch = r;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  // one block holds the whole sequence so priorities read top-down:
  // bus initialize beats everything, then errors, then the button
  always_comb begin
    logic press;
    logic crc_stop;
    press    = 1'b0;
    crc_stop = 1'b0;
    s_nxt       = s_r;
    s_nxt.go    = 1'b0;
    s_nxt.abort = 1'b0;
    s_nxt.btn_q = pnl.start_btn;
    // a rising edge is one press; software may lock the button out
    press = pnl.start_btn && !s_r.btn_q && !s_r.ctrl_inh;

    // free-running flash timer shared by all flashing codes
    if (s_r.blink_tmr == FLASH_LAST) begin
      s_nxt.blink_tmr = '0;
      s_nxt.blink     = !s_r.blink;
    end else begin
      s_nxt.blink_tmr = s_r.blink_tmr + 1'b1;
    end

    // moving the mode switch away drops the winchester enable
    if (s_r.wen && pnl.mode_sw != s_r.wen_mode) begin
      s_nxt.wen = 1'b0;
    end

    unique case (s_r.st)
      dps_pkg::ST_IDLE, dps_pkg::ST_DONE, dps_pkg::ST_FAIL: begin
        if (press) begin
          s_nxt = launch(s_nxt, pnl, eng);
        end
      end
      dps_pkg::ST_RUN: begin
        if (eng.err_valid && is_crc(eng.err_code)) begin
          // CRC errors only count; the sixteenth one stops the test
          s_nxt.crc_cnt = s_r.crc_cnt + 1'b1;
          crc_stop      = (s_r.crc_cnt + 5'h01) == dps_pkg::CRC_LIMIT;
          if (crc_stop) begin
            s_nxt       = fail(s_nxt, eng.err_code, !eng.err_win, eng.err_win);
            s_nxt.abort = 1'b1;
          end
        end else if (eng.err_valid) begin
          s_nxt       = fail(s_nxt, eng.err_code, !eng.err_win, eng.err_win);
          s_nxt.abort = 1'b1;
        end else if (eng.pass_done && eng.pass_repeat) begin
          s_nxt.st       = dps_pkg::ST_GAP;
          s_nxt.tmr      = '0;
          s_nxt.repeat_q = 1'b1;
        end else if (eng.pass_done) begin
          s_nxt.st       = dps_pkg::ST_DONE;
          s_nxt.err_code = dps_pkg::CODE_OK;
        end else if (press && s_r.mode_q != dps_pkg::MODE_FORMAT) begin
          s_nxt.abort = 1'b1;
          s_nxt       = launch(s_nxt, pnl, eng);
        end
      end
      dps_pkg::ST_GAP: begin
        if (press && s_r.mode_q != dps_pkg::MODE_FORMAT) begin
          s_nxt.abort = 1'b1;
          s_nxt       = launch(s_nxt, pnl, eng);
        end else if (s_r.tmr == GAP_LAST) begin
          // one second of 00 done: start the next pass
          s_nxt.st = dps_pkg::ST_RUN;
          s_nxt.go = 1'b1;
        end else begin
          s_nxt.tmr = s_r.tmr + 1'b1;
        end
      end
    endcase

    // the host reset wins over every panel action, even during format
    if (bus_init) begin
      s_nxt.abort = (s_r.st == dps_pkg::ST_RUN) || (s_r.st == dps_pkg::ST_GAP);
      s_nxt.go    = 1'b0;
      s_nxt.st    = dps_pkg::ST_IDLE;
    end

    // drive operations never run in the controller test mode
    s_nxt.drv_en = (s_nxt.st == dps_pkg::ST_RUN || s_nxt.st == dps_pkg::ST_GAP) &&
                   (s_nxt.mode_q != dps_pkg::MODE_CTRL);

    // lamps follow the failure; composite lights with either drive
    s_nxt.comp_lamp = (s_nxt.st == dps_pkg::ST_FAIL);
    s_nxt.flp_lamp  = (s_nxt.st == dps_pkg::ST_FAIL) && s_nxt.err_flp;
    s_nxt.win_lamp  = (s_nxt.st == dps_pkg::ST_FAIL) && s_nxt.err_win;

    // digit patterns come from the decoders below
    s_nxt.seg_hi = seg_hi_w;
    s_nxt.seg_lo = seg_lo_w;

    // register writes; unmapped addresses are ignored
    if (bus.wr && bus.addr == dps_pkg::REG_CTRL) begin
      s_nxt.ctrl_inh = bus.wdata[dps_pkg::CTRL_INH_BIT];
    end

    // read data stands only in the cycle after the strobe
    s_nxt.rdata = 16'h0000;
    if (bus.rd) begin
      unique case (bus.addr)
        dps_pkg::REG_STATUS: s_nxt.rdata = {1'b0, s_r.repeat_q, s_r.blink, s_r.err_win,
                                            s_r.err_flp, s_r.crc_cnt, s_r.wen,
                                            s_r.st};
        dps_pkg::REG_CTRL:   s_nxt.rdata = {15'h0000, s_r.ctrl_inh};
        dps_pkg::REG_CODE:   s_nxt.rdata = {1'b0, s_r.wen_mode, s_r.class_q,
                                            s_r.mode_q, s_r.err_code};
        default:             s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // display source
  // ****************************************************************
  // the held button echoes the switches; otherwise the state decides
  always_comb begin
    dig_hi    = 3'h0;
    dig_lo    = 3'h0;
    dig_blank = 1'b0;
    if (pnl.start_btn) begin
      dig_hi = pnl.mode_sw;
      dig_lo = pnl.class_sw;
    end else begin
      unique case (s_nxt.st)
        dps_pkg::ST_IDLE: begin
          // idle panel mirrors the switches, which the switch test relies on
          dig_hi = pnl.mode_sw;
          dig_lo = pnl.class_sw;
        end
        dps_pkg::ST_RUN: begin
          dig_hi = s_nxt.mode_q;
          dig_lo = s_nxt.class_q;
        end
        dps_pkg::ST_GAP, dps_pkg::ST_DONE: begin
          dig_hi = 3'h0;
          dig_lo = 3'h0;
        end
        dps_pkg::ST_FAIL: begin
          // six-bit code splits into two octal digits, so no 8 or 9 ever
          dig_hi    = s_nxt.err_code[5:3];
          dig_lo    = s_nxt.err_code[2:0];
          dig_blank = !s_nxt.blink;
        end
      endcase
    end
  end

  // two identical digit decoders
  dps_octal_seg u_seg_hi (
    .digit (dig_hi),
    .blank (dig_blank),
    .seg   (seg_hi_w)
  );

  dps_octal_seg u_seg_lo (
    .digit (dig_lo),
    .blank (dig_blank),
    .seg   (seg_lo_w)
  );

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r          <= '0;
      s_r.st       <= dps_pkg::ST_IDLE;
      s_r.err_code <= dps_pkg::CODE_OK;
      s_r.ctrl_inh <= dps_pkg::CTRL_RESET;
      s_r.btn_q    <= 1'b1; // a button held through reset is no press
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs, all straight from the state register
  // ****************************************************************
  // no output depends on the host cable beyond the initialize line and the register port
  assign cmd.go           = s_r.go;
  assign cmd.abort        = s_r.abort;
  assign cmd.mode         = s_r.mode_q;
  assign cmd.cls          = s_r.class_q;
  assign cmd.drive_ops_en = s_r.drv_en;
  assign disp.seg_hi      = s_r.seg_hi;
  assign disp.seg_lo      = s_r.seg_lo;
  assign disp.comp_fault  = s_r.comp_lamp;
  assign disp.flp_fault   = s_r.flp_lamp;
  assign disp.win_fault   = s_r.win_lamp;
  assign rdata            = s_r.rdata;
endmodule

// ### inc/dps_pkg.sv
// package of the diagnostic panel sequencer: codes, states, layouts.
// assumes one 125 MHz clock; panel inputs already debounced and synchronous.
package dps_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned GAP_MS       = 1000;      // pause showing 00
  localparam int unsigned FLASH_MS     = 250;       // half period of flashing
  localparam int unsigned GAP_CYCLES   = CLK_HZ / 1000 * GAP_MS;
  localparam int unsigned FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned TMR_W        = 27;

  // ****************************************************************
  // modes, classes and error codes (octal values, two octal digits)
  // ****************************************************************
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_FORMAT = 3'h1;
  localparam logic [2:0] MODE_SYSTEM = 3'h2;
  localparam logic [2:0] MODE_CTRL   = 3'h3;
  localparam logic [2:0] MODE_RW     = 3'h5;
  localparam logic [2:0] MODE_BAD    = 3'h7;
  localparam logic [2:0] CLASS_WEN   = 3'h7;
  localparam logic [5:0] CODE_OK     = 6'h00;   // octal 00
  localparam logic [5:0] CODE_WPROT  = 6'h08;   // octal 10
  localparam logic [5:0] CODE_HCRC   = 6'h0c;   // octal 14
  localparam logic [5:0] CODE_DCRC   = 6'h10;   // octal 20
  localparam logic [5:0] CODE_NRDY   = 6'h1e;   // octal 36
  localparam logic [5:0] CODE_BADCLS = 6'h22;   // octal 42
  localparam logic [4:0] CRC_LIMIT   = 5'h10;   // sixteen decimal

  // ****************************************************************
  // register port map and fields
  // ****************************************************************
  localparam logic [1:0] REG_STATUS  = 2'h0;
  localparam logic [1:0] REG_CTRL    = 2'h1;
  localparam logic [1:0] REG_CODE    = 2'h2;
  localparam int unsigned CTRL_INH_BIT = 0;
  localparam logic        CTRL_RESET   = 1'h0;

  // one-hot sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RUN  = 5'h02,
    ST_GAP  = 5'h04,
    ST_DONE = 5'h08,
    ST_FAIL = 5'h10
  } dps_state_t;

  // front panel switches and drive status
  typedef struct packed {
    logic [2:0] mode_sw;
    logic [2:0] class_sw;
    logic       start_btn;
    logic       floppy_in;
    logic       flp_wp;
    logic       win_wp;
  } dps_panel_t;

  // reports and needs from the microcoded test library
  typedef struct packed {
    logic       err_valid;
    logic [5:0] err_code;
    logic       err_win;
    logic       pass_done;
    logic       pass_repeat;
    logic       req_floppy;
    logic       req_fwrite;
    logic       req_wwrite;
  } dps_eng_t;

  // commands to the test library
  typedef struct packed {
    logic       go;
    logic       abort;
    logic [2:0] mode;
    logic [2:0] cls;
    logic       drive_ops_en;
  } dps_cmd_t;

  // displays and lamps
  typedef struct packed {
    logic [6:0] seg_hi;
    logic [6:0] seg_lo;
    logic       comp_fault;
    logic       flp_fault;
    logic       win_fault;
  } dps_disp_t;

  // register port request
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dps_bus_t;
endpackage

// ### logic/dps_octal_seg.sv
// octal digit to seven-segment pattern, segments gfedcba, active high.
// assumes the caller registers the pattern before it reaches a pin.
module dps_octal_seg (
  // digit in
  input  wire logic [2:0] digit,
  input  wire logic       blank,
  // pattern out
  output logic      [6:0] seg
);

  // ****************************************************************
  // decode
  // ****************************************************************
  // octal digits only, so eight and nine have no pattern at all
  always_comb begin
    unique case (digit)
      3'h0: seg = 7'h3f;
      3'h1: seg = 7'h06;
      3'h2: seg = 7'h5b;
      3'h3: seg = 7'h4f;
      3'h4: seg = 7'h66;
      3'h5: seg = 7'h6d;
      3'h6: seg = 7'h7d;
      3'h7: seg = 7'h07;
    endcase
    if (blank) begin
      seg = 7'h00;
    end
  end
endmodule

// ### testbench/dps_panel_model.sv
// operator front panel model: switches, a held pushbutton, digit reading.
// assumes bench requests on press arrive as one-cycle pulses on clk.
module dps_panel_model (
  // clock
  input  wire logic               clk,
  // operator actions
  input  wire logic [2:0]         mode,
  input  wire logic [2:0]         cls,
  input  wire logic               press,
  input  wire logic [2:0]         media,
  // panel pins
  output dps_pkg::dps_panel_t     pnl,
  input  wire dps_pkg::dps_disp_t disp,
  // digits read back, 4'hf when blank or unreadable
  output logic [3:0]              dig_hi,
  output logic [3:0]              dig_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SEG [8] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07};
  logic [1:0] held_r = 2'h0;

  // an unknown pattern reads as blank, so it never matches a digit
  function automatic logic [3:0] dec(input logic [6:0] s);
    dec = 4'hf;
    for (int i = 0; i < 8; i++) begin
      if (s === SEG[i]) dec = 4'(i);
    end
  endfunction

  // a press is held three cycles, like a thumb, then let go
  always @(posedge clk) begin
    if (press) begin
      held_r <= 2'h3;
    end else if (held_r != 2'h0) begin
      held_r <= held_r - 2'h1;
    end
  end

  // pins and readings
  assign pnl    = {mode, cls, held_r != 2'h0, media};
  assign dig_hi = dec(disp.seg_hi);
  assign dig_lo = dec(disp.seg_lo);
endmodule

// ### testbench/dps_sequencer_chk.sv
// port checker of the panel sequencer.
// assumes the engine stays quiet while a pause between passes runs.
module dps_sequencer_chk #(
  parameter int unsigned GAP_CYCLES   = dps_pkg::GAP_CYCLES,
  parameter int unsigned FLASH_CYCLES = dps_pkg::FLASH_CYCLES
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                reset,
  // watched ports
  input wire dps_pkg::dps_panel_t pnl,
  input wire dps_pkg::dps_disp_t  disp,
  input wire logic                bus_init,
  input wire dps_pkg::dps_eng_t   eng,
  input wire dps_pkg::dps_cmd_t   cmd,
  input wire dps_pkg::dps_bus_t   bus,
  input wire logic [15:0]         rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // helpers
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic arm_r;
  int   gap_r;
  logic crc_w;
  logic wsel_w;

  // crc reports only count; write enable classes live in modes 2 and 5
  assign crc_w  = eng.err_code == dps_pkg::CODE_HCRC || eng.err_code == dps_pkg::CODE_DCRC;
  assign wsel_w = pnl.mode_sw == dps_pkg::MODE_SYSTEM || pnl.mode_sw == dps_pkg::MODE_RW;

  // cycles since a repeating pass ended; any launch or abort clears it
  always_ff @(posedge clk) begin
    if (reset || cmd.go || cmd.abort) begin
      arm_r <= 1'b0;
      gap_r <= 0;
    end else if (eng.pass_done && eng.pass_repeat && cmd.drive_ops_en && !eng.err_valid) begin
      arm_r <= 1'b1;
      gap_r <= 1;
    end else if (arm_r) begin
      gap_r <= gap_r + 1;
    end
  end

  // ********
  // properties
  // ********
  go_pulse_a: assert property (cmd.go |=> !cmd.go)
    else $error("launch pulse longer than one cycle");
  init_abort_a: assert property (bus_init && cmd.drive_ops_en |=> cmd.abort && !cmd.drive_ops_en)
    else $error("host initialize did not abort");
  ctrl_quiet_a: assert property (cmd.mode == dps_pkg::MODE_CTRL |-> !cmd.drive_ops_en)
    else $error("controller test allowed drive work");
  lamp_comp_a: assert property (disp.flp_fault || disp.win_fault |-> disp.comp_fault)
    else $error("drive lamp without composite lamp");
  err_stop_a: assert property (eng.err_valid && !crc_w && cmd.drive_ops_en && !arm_r
    && !bus_init |=> cmd.abort && disp.comp_fault && disp.win_fault == $past(eng.err_win))
    else $error("error did not end the test");
  wen_nogo_a: assert property ($rose(pnl.start_btn) && wsel_w
    && pnl.class_sw == dps_pkg::CLASS_WEN && !cmd.drive_ops_en |=> !cmd.go && !disp.comp_fault)
    else $error("write enable press misbehaved");
  bad_mode_a: assert property ($rose(pnl.start_btn) && pnl.mode_sw == dps_pkg::MODE_BAD
    && !cmd.drive_ops_en && !bus_init |=> !cmd.go ##0 disp.comp_fault && !disp.win_fault)
    else $error("invalid selection not refused");
  gap_len_a: assert property (arm_r && cmd.go |-> gap_r + 1 >= GAP_CYCLES && gap_r <= GAP_CYCLES + 2)
    else $error("pause between passes has wrong length");
  gap_zero_a: assert property (arm_r && $past(arm_r) && !cmd.go |-> disp.seg_hi == 7'h3f && disp.seg_lo == 7'h3f)
    else $error("pause does not show 00");
endmodule

bind dps_sequencer dps_sequencer_chk #(
  .GAP_CYCLES  (GAP_CYCLES),
  .FLASH_CYCLES(FLASH_CYCLES)
) dps_sequencer_chk_i (
  .clk(clk), .reset(reset), .pnl(pnl), .disp(disp), .bus_init(bus_init),
  .eng(eng), .cmd(cmd), .bus(bus), .rdata(rdata)
);

// ### testbench/testbench.sv
// self-checking bench of the panel sequencer: reset checks, launch table, then hand tests.
// assumes the panel model drives the switches and the checker is bound.
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAPC = 20;
  typedef struct packed {
    logic [2:0] m;
    logic [2:0] c;
    logic [2:0] need;
    logic [2:0] media;
    logic       go;
    logic [5:0] code;
    logic [2:0] lamp;
  } dps_row_t;
  logic                clk;
  logic                reset;
  logic                press;
  logic                bus_init;
  logic                ab;
  logic [2:0]          mode;
  logic [2:0]          cls;
  logic [2:0]          media;
  logic [3:0]          dig_hi;
  logic [3:0]          dig_lo;
  logic [3:0]          hi2;
  logic [3:0]          lo2;
  logic [15:0]         rdata;
  logic [15:0]         q;
  dps_pkg::dps_panel_t pnl;
  dps_pkg::dps_disp_t  disp;
  dps_pkg::dps_eng_t   eng;
  dps_pkg::dps_cmd_t   cmd;
  dps_pkg::dps_bus_t   bus;
  wire logic [2:0]     lamps = {disp.comp_fault, disp.flp_fault, disp.win_fault};
  int                  err_count = 0;
  int                  num_checks = 0;
  int                  g;
  int                  a;
  int                  n;
  // mode, class, needs, media, go, code, lamps
  dps_row_t rows [13] = '{
    '{3'h0, 3'h0, 3'h0, 3'h4, 1'h1, 6'h00, 3'h0}, '{3'h7, 3'h0, 3'h0, 3'h4, 1'h0, 6'h22, 3'h4},
    '{3'h2, 3'h1, 3'h4, 3'h0, 1'h0, 6'h1e, 3'h6}, '{3'h2, 3'h2, 3'h2, 3'h6, 1'h0, 6'h08, 3'h6},
    '{3'h2, 3'h3, 3'h1, 3'h4, 1'h0, 6'h08, 3'h5}, '{3'h5, 3'h7, 3'h0, 3'h4, 1'h0, 6'h00, 3'h0},
    '{3'h5, 3'h1, 3'h1, 3'h4, 1'h1, 6'h00, 3'h0}, '{3'h5, 3'h2, 3'h1, 3'h5, 1'h0, 6'h08, 3'h5},
    '{3'h2, 3'h4, 3'h1, 3'h4, 1'h0, 6'h08, 3'h5}, '{3'h3, 3'h4, 3'h0, 3'h4, 1'h1, 6'h00, 3'h0},
    '{3'h4, 3'h2, 3'h0, 3'h4, 1'h1, 6'h00, 3'h0}, '{3'h6, 3'h3, 3'h0, 3'h4, 1'h1, 6'h00, 3'h0},
    '{3'h1, 3'h0, 3'h0, 3'h4, 1'h1, 6'h00, 3'h0}};

  dps_sequencer #(.GAP_CYCLES(GAPC), .FLASH_CYCLES(4)) dps_sequencer_i (
    .clk(clk), .reset(reset), .pnl(pnl), .disp(disp), .bus_init(bus_init),
    .eng(eng), .cmd(cmd), .bus(bus), .rdata(rdata));
  dps_panel_model dps_panel_model_i (.clk(clk), .mode(mode), .cls(cls), .press(press),
    .media(media), .pnl(pnl), .disp(disp), .dig_hi(dig_hi), .dig_lo(dig_lo));

  // ********
  // tasks
  // ********
  // press, then watch six cycles; the display is kept while still held
  task automatic push();
    g = 0;
    a = 0;
    press <= 1'b1;
    @(posedge clk);
    #1;
    press <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      #1;
      g += int'(cmd.go === 1'b1);
      a += int'(cmd.abort === 1'b1);
      if (i == 1) {hi2, lo2} = {dig_hi, dig_lo};
    end
  endtask
  // one engine report; an idle edge follows so no pulse is set twice at once
  task automatic ev(input logic e, input logic p, input logic rp, input logic w,
                    input logic [5:0] c);
    eng.err_valid <= e;
    eng.pass_done <= p;
    eng.pass_repeat <= rp;
    eng.err_win <= w;
    eng.err_code <= c;
    @(posedge clk);
    #1;
    ab = cmd.abort;
    eng.err_valid <= 1'b0;
    eng.pass_done <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // register access; read data stand only in the cycle after the strobe
  task automatic acc(input logic w, input logic [1:0] ad, input logic [15:0] d,
                     output logic [15:0] r);
    bus <= {ad, d, w, ~w};
    @(posedge clk);
    #1;
    r = rdata;
    bus <= '0;
    @(posedge clk);
    #1;
  endtask
  // a flashing code is read in its lit phase
  task automatic show(input logic [5:0] c);
    int k;
    k = 0;
    while (dig_hi === 4'hf && k < 12) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK("code", {1'b0, c[5:3], 1'b0, c[2:0]}, {dig_hi, dig_lo})
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ********
  // clock and watchdog
  // ********
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // the run needs under 1000 cycles; the 75 us limit, over 9000 cycles, is a hang
  initial begin
    #75us;
    err_count++;
    report_and_stop();
  end

  // ********
  // main sequence
  // ********
  initial begin
    reset = 1'b1;
    press = 1'b0;
    bus_init = 1'b0;
    mode = 3'h2;
    cls = 3'h0;
    media = 3'h4;
    eng = '0;
    bus = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("go", 1'b0, cmd.go)
    `CHK("lamps", 3'h0, lamps)
    acc(1'b0, dps_pkg::REG_STATUS, 16'h0000, q);
    `CHK("status", 16'h0001, q & 16'hdfff)
    acc(1'b1, dps_pkg::REG_CTRL, 16'h0001, q);
    acc(1'b0, dps_pkg::REG_CTRL, 16'h0000, q);
    `CHK("ctrl", 16'h0001, q)
    push();
    `CHK("inhibit", 0, g)
    acc(1'b1, dps_pkg::REG_CTRL, 16'h0000, q);
    acc(1'b0, 2'h3, 16'h0000, q);
    `CHK("unmapped", 16'h0000, q)
    done("reset");
    foreach (rows[i]) begin
      mode <= rows[i].m;
      cls <= rows[i].c;
      media <= rows[i].media;
      {eng.req_floppy, eng.req_fwrite, eng.req_wwrite} <= rows[i].need;
      bus_init <= 1'b1;
      @(posedge clk);
      #1;
      bus_init <= 1'b0;
      @(posedge clk);
      #1;
      push();
      `CHK("go", rows[i].go, g)
      if (rows[i].go) begin
        `CHK("echo", {1'b0, rows[i].m, 1'b0, rows[i].c}, {hi2, lo2})
        `CHK("run", {1'b0, rows[i].m, 1'b0, rows[i].c}, {dig_hi, dig_lo})
        `CHK("ops", rows[i].m != 3'h3, cmd.drive_ops_en)
        `CHK("sel", {rows[i].m, rows[i].c}, {cmd.mode, cmd.cls})
      end else begin
        show(rows[i].code);
        `CHK("lamps", rows[i].lamp, lamps)
      end
    end
    done("table");
    mode <= 3'h2;
    push();
    `CHK("fmt", 0, g + a)
    ev(1'b0, 1'b1, 1'b0, 1'b0, 6'h00);
    show(6'h00);
    push();
    cls <= 3'h5;
    push();
    `CHK("relaunch", 2'h3, {g == 1, a == 1})
    done("format");
    n = 0;
    for (int i = 0; i < 15; i++) begin
      ev(1'b1, 1'b0, 1'b0, 1'b0, i[0] ? 6'h10 : 6'h0c);
      n += int'(ab === 1'b1);
    end
    `CHK("crc15", 0, n)
    ev(1'b1, 1'b0, 1'b0, 1'b1, 6'h10);
    `CHK("crc16", 1'b1, ab)
    show(6'h10);
    done("crc");
    for (int c = 1; c < 6'h2c; c++) begin
      if (c inside {6'h09, 6'h0c, 6'h10, 6'h1b, 6'h1c, 6'h28}) continue;
      push();
      ev(1'b1, 1'b0, 1'b0, c[0], 6'(c));
      `CHK("stop", 1'b1, ab)
      show(6'(c));
      `CHK("lamps", {1'b1, ~c[0], c[0]}, lamps)
    end
    done("codes");
    push();
    ev(1'b0, 1'b1, 1'b1, 1'b0, 6'h00);
    show(6'h00);
    n = 1;
    while (cmd.go !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("pause", 1'b1, n >= GAPC - 1 && n <= GAPC + 2)
    bus_init <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("init", 1'b1, cmd.abort)
    bus_init <= 1'b0;
    repeat (2) @(posedge clk);
    done("repeat");
    report_and_stop();
  end
endmodule
